// >>> verilog/rtc_two_wire_target_port.sv
// target end of the two-wire port: framing, address match, pointer
// assumes scl/sda levels arrive synchronous to sys_clk, oversampled
`timescale 1ns/1ps
module rtc_two_wire_target_port
  import two_wire_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  two_wire_if.target      bus,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic      [7:0] rd_ptr,
  input  wire logic [7:0] rd_data,
  output logic            rd_load,
  output logic            busy,
  output logic            restart
);
  // ************************************************************
  // line sampling and conditions
  // ************************************************************
  logic       scl_q;
  logic       sda_q;
  logic       scl;
  logic       sda;
  logic       start_c;
  logic       stop_c;
  logic       rise;
  logic       fall;
  tgt_state_t state_q;
  tgt_state_t state_d;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic       first_q;
  logic       rw_q;
  logic       mack_q;
  logic       oe_q;
  logic       busy_q;
  logic       restart_q;
  logic       rd_load_q;
  logic       rx_st;
  logic       byte_done;
  logic       match;
  logic       fifo_rdy;
  logic       push;
  logic       accept;

  assign scl = bus.scl_i;
  assign sda = bus.sda_i;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // sda moving while scl stays high is never data
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c  = scl && scl_q && !sda_q && sda;
  assign rise    = scl && !scl_q;
  assign fall    = !scl && scl_q;

  // ************************************************************
  // byte decisions
  // ************************************************************
  assign rx_st     = (state_q == ST_ADDR) || (state_q == ST_WR);
  assign byte_done = rx_st && fall && (cnt_q == 4'(BYTE_BITS));
  assign match     = sh_q[7:1] == TARGET_ADDR;
  // a full fifo refuses the byte with a missing acknowledge
  assign accept    = first_q || fifo_rdy;
  assign push      = (state_q == ST_WR) && byte_done && !first_q && fifo_rdy;

  // ************************************************************
  // state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ADDR: begin
        if (byte_done) begin
          state_d = match ? ST_ACK : ST_WAIT;
        end
      end
      ST_WR: begin
        if (byte_done) begin
          state_d = accept ? ST_ACK : ST_WAIT;
        end
      end
      ST_ACK: begin
        if (fall) begin
          state_d = rw_q ? ST_RD : ST_WR;
        end
      end
      ST_RD: begin
        if (fall && (cnt_q == 4'(BYTE_BITS - 1))) begin
          state_d = ST_MACK;
        end
      end
      ST_MACK: begin
        if (fall) begin
          state_d = mack_q ? ST_RD : ST_WAIT;
        end
      end
      ST_IDLE, ST_WAIT: begin
        state_d = state_q;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (start_c) begin
      state_d = ST_ADDR;
    end else if (stop_c) begin
      state_d = ST_IDLE;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // bit counter and shifter
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (start_c) begin
      cnt_q <= 4'h0;
    end else if (fall && ((state_q == ST_ACK) || (state_q == ST_MACK))) begin
      cnt_q <= 4'h0;
    end else if (rx_st && rise) begin
      cnt_q <= cnt_q + 4'h1;
    end else if ((state_q == ST_RD) && fall) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
    end else if (rx_st && rise) begin
      sh_q <= {sh_q[6:0], sda};
    end else if (fall && (state_q == ST_ACK) && rw_q) begin
      sh_q <= rd_data;
    end else if (fall && (state_q == ST_MACK) && mack_q) begin
      sh_q <= rd_data;
    end else if (fall && (state_q == ST_RD)) begin
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // ************************************************************
  // transaction flags and register pointer
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
    end else begin
      if (start_c) begin
        first_q <= 1'b1;
      end else if ((state_q == ST_WR) && byte_done) begin
        first_q <= 1'b0;
      end
      if ((state_q == ST_ADDR) && byte_done && match) begin
        rw_q <= sh_q[0] == DIR_READ;
      end
      if ((state_q == ST_MACK) && rise) begin
        mack_q <= !sda;
      end
    end
  end
  // pointer survives stop so a plain read continues where writes left off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= PTR_RESET;
    end else if ((state_q == ST_WR) && byte_done && first_q) begin
      ptr_q <= sh_q;
    end else if (push) begin
      ptr_q <= ptr_q + 8'h01;
    end else if ((state_q == ST_RD) && fall && (cnt_q == 4'(BYTE_BITS - 1))) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // ************************************************************
  // open-drain data drive
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (start_c || stop_c) begin
      oe_q <= 1'b0;
    end else if (byte_done) begin
      oe_q <= (state_q == ST_ADDR) ? match : accept;
    end else if (fall) begin
      case (state_q)
        ST_ACK:  oe_q <= rw_q && !rd_data[7];
        ST_RD:   oe_q <= (cnt_q != 4'(BYTE_BITS - 1)) && !sh_q[6];
        ST_MACK: oe_q <= mack_q && !rd_data[7];
        default: oe_q <= 1'b0;
      endcase
    end
  end
  assign bus.t_sda_o  = 1'b0;
  assign bus.t_sda_oe = oe_q;

  // ************************************************************
  // bank side
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q    <= 1'b0;
      restart_q <= 1'b0;
      rd_load_q <= 1'b0;
    end else begin
      busy_q    <= start_c ? 1'b1 : (stop_c ? 1'b0 : busy_q);
      restart_q <= start_c && busy_q;
      rd_load_q <= fall && rw_q && ((state_q == ST_ACK) ||
                   ((state_q == ST_MACK) && mack_q));
    end
  end
  assign busy    = busy_q;
  assign restart = restart_q;
  assign rd_load = rd_load_q;
  assign rd_ptr  = ptr_q;

  word_fifo #(.WIDTH(16), .DEPTH(FIFO_D)) u_wr_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   ({ptr_q, sh_q}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );
endmodule : rtc_two_wire_target_port

// >>> verilog/two_wire_pkg.sv
// constants, encodings and timing for the two-wire serial port ends
// assumes a single 125 MHz sys_clk shared by both ends and the bench
// Contract
// - SDA falls, SCL high: START or repeated START
// - SDA rises, SCL high: STOP ends transaction
// - bytes of eight bits, no byte limit
// - pointer advances after each byte, both directions; a write byte refused on a full fifo leaves it unchanged
// - change SDA while SCL low, sample high
// - SDA change with SCL high is condition
// - receiver acknowledges each byte, active low; target leaves a write byte unacknowledged when its fifo is full
// - ack driven right after eighth falling edge
// - ack released at ninth falling edge
// - master NACK ends read, target waits STOP
// - respond only to own address, else silent
// - seven bit address, direction bit as LSB
// - master never touches test addresses 49h, 4Ah; code refuses only pointer bytes 49h/4Ah, auto-increment can still reach them
// - lines idle high, open-drain drive only
package two_wire_pkg;
  // ************************************************************
  // addresses and codes
  // ************************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h68;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic [7:0] TEST_ADDR_A = 8'h49;
  localparam logic [7:0] TEST_ADDR_B = 8'h4A;
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam int         BYTE_BITS   = 8;
  localparam int         FIFO_DEPTH  = 4;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_NS        = SCL_PERIOD_NS / 4;
  localparam int QTR_CYC       = (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ACK = 3'h3, ST_WR = 3'h2,
    ST_RD = 3'h6, ST_MACK = 3'h7, ST_WAIT = 3'h5
  } tgt_state_t;
  typedef enum logic [1:0] {
    OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3
  } op_t;
  typedef enum logic {M_IDLE = 1'b0, M_RUN = 1'b1} mst_state_t;
endpackage : two_wire_pkg

// >>> verilog/two_wire_if.sv
// open-drain two-wire bus joining master and target ends
// assumes pull-ups: a line is high unless some enabled driver pulls low
`timescale 1ns/1ps
interface two_wire_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl_i;
  logic sda_i;
  // wired-and of all drivers against the pull-up
  assign scl_i = !(m_scl_oe && !m_scl_o);
  assign sda_i = !((m_sda_oe && !m_sda_o) || (t_sda_oe && !t_sda_o));
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl_i, sda_i);
  modport target (output t_sda_o, t_sda_oe, input scl_i, sda_i);
endinterface : two_wire_if

// >>> verilog/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  // extra pointer bit tells full from empty
  assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (in_valid && in_ready) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : word_fifo

// >>> verilog/two_wire_master_end.sv
// master end: turns start/stop/byte commands into bus cycles
// assumes the command side holds cmd_* steady while cmd_valid is high
`timescale 1ns/1ps
module two_wire_master_end
  import two_wire_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  two_wire_if.master      bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_nack,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            rsp_nack,
  output logic            rsp_refused,
  output logic            busy
);
  localparam int TW = $clog2(QTR + 1);
  function automatic logic is_test(input logic [7:0] b);
    return (b == TEST_ADDR_A) || (b == TEST_ADDR_B);
  endfunction : is_test
  // ************************************************************
  // command intake and quarter timer
  // ************************************************************
  mst_state_t    state_q;
  op_t           op_q;
  logic [8:0]    tx_q;
  logic [7:0]    dat_q;
  logic [7:0]    rx_q;
  logic [3:0]    slot_q;
  logic [1:0]    qtr_q;
  logic [TW-1:0] tmr_q;
  logic          scl_oe_q;
  logic          sda_oe_q;
  logic          ack_q;
  logic          ptr_next_q;
  logic          tick;
  logic          accept;
  logic          refuse;
  logic          last;
  logic          is_byte;

  assign cmd_ready = state_q == M_IDLE;
  assign accept    = cmd_ready && cmd_valid;
  // pointer byte aimed at the test area is never put on the bus
  assign refuse    = accept && (cmd_op == OP_WRITE) && ptr_next_q && is_test(cmd_data);
  assign tick      = (state_q == M_RUN) && (tmr_q == TW'(QTR - 1));
  assign is_byte   = (op_q == OP_WRITE) || (op_q == OP_READ);
  assign last      = tick && (qtr_q == 2'h3) && (slot_q == (is_byte ? 4'h8 : 4'h0));
  assign busy      = state_q == M_RUN;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
    end else if (accept || tick) begin
      tmr_q <= '0;
    end else if (state_q == M_RUN) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= M_IDLE;
      op_q    <= OP_START;
      tx_q    <= 9'h1FF;
      dat_q   <= 8'h00;
      slot_q  <= 4'h0;
      qtr_q   <= 2'h0;
    end else if (accept && !refuse) begin
      state_q <= M_RUN;
      op_q    <= op_t'(cmd_op);
      // a read releases sda for data bits, then sends its own ack choice
      tx_q    <= (cmd_op == OP_READ) ? {8'hFF, cmd_nack} : {cmd_data, 1'b1};
      dat_q   <= cmd_data;
      slot_q  <= 4'h0;
      qtr_q   <= 2'h0;
    end else if (tick) begin
      qtr_q <= qtr_q + 2'h1;
      if (qtr_q == 2'h3) begin
        slot_q  <= slot_q + 4'h1;
        tx_q    <= {tx_q[7:0], 1'b1};
        state_q <= last ? M_IDLE : M_RUN;
      end
    end
  end

  // ************************************************************
  // line drive, quarters 0-1 scl low, 2-3 scl high
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (accept && !refuse) begin
      scl_oe_q <= 1'b1;
    end else if (tick) begin
      scl_oe_q <= (qtr_q == 2'h3) ? !last : (qtr_q == 2'h0);
      if (qtr_q == 2'h0) begin
        case (op_q)
          OP_START: sda_oe_q <= 1'b0;
          OP_STOP:  sda_oe_q <= 1'b1;
          default:  sda_oe_q <= !tx_q[8];
        endcase
      end else if (qtr_q == 2'h2) begin
        case (op_q)
          OP_START: sda_oe_q <= 1'b1;
          OP_STOP:  sda_oe_q <= 1'b0;
          default:  sda_oe_q <= sda_oe_q;
        endcase
      end
    end
  end
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_q;
  assign bus.m_sda_oe = sda_oe_q;

  // ************************************************************
  // sampling and answers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q  <= 8'h00;
      ack_q <= 1'b1;
    end else if (tick && (qtr_q == 2'h2) && is_byte) begin
      if (slot_q == 4'h8) begin
        ack_q <= bus.sda_i;
      end else begin
        rx_q <= {rx_q[6:0], bus.sda_i};
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_next_q <= 1'b0;
    end else if (last) begin
      ptr_next_q <= (op_q == OP_WRITE) && !ack_q && (dat_q == {TARGET_ADDR, 1'b0});
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid   <= 1'b0;
      rsp_data    <= 8'h00;
      rsp_nack    <= 1'b0;
      rsp_refused <= 1'b0;
    end else begin
      rsp_valid   <= refuse || (last && is_byte);
      rsp_refused <= refuse;
      if (last && is_byte) begin
        rsp_data <= rx_q;
        rsp_nack <= ack_q;
      end
    end
  end
endmodule : two_wire_master_end

// >>> tb/two_wire_monitor.sv
// checker for the open-drain bus between the master end and the target end
// assumes it sees the interface signals as plain inputs, all on sys_clk
`timescale 1ns/1ps
module two_wire_monitor #(
  parameter int QTR = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic t_sda_o,
  input wire logic t_sda_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  // ************************************************************
  // helper logic
  // ************************************************************
  logic [7:0] low_cnt_q;
  logic [7:0] high_cnt_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       frame_q;
  logic       start_c;
  logic       stop_c;
  // previous levels reset high so that reset release never looks like a condition
  assign start_c = scl_i && scl_p_q && sda_p_q && !sda_i;
  assign stop_c  = scl_i && scl_p_q && !sda_p_q && sda_i;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_i;
      sda_p_q <= sda_i;
    end
  end
  // saturating counts, scl may rest high for a long time between commands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) low_cnt_q <= 8'h00;
    else if (scl_i) low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    // reset counts as a long idle high phase, so the first command is not short
    if (!rst_n) high_cnt_q <= 8'hFF;
    else if (!scl_i) high_cnt_q <= 8'h00;
    else if (high_cnt_q != 8'hFF) high_cnt_q <= high_cnt_q + 8'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) frame_q <= 1'b0;
    else if (start_c) frame_q <= 1'b1;
    else if (stop_c) frame_q <= 1'b0;
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  open_drain_a: assert property (
    !m_scl_o && !m_sda_o && !t_sda_o) else $error("bus driven high");
  tgt_edge_a: assert property (
    $changed(t_sda_oe) |-> !scl_i && !$past(scl_i)) else $error("target moved sda, scl high");
  scl_low_a: assert property (
    $rose(scl_i) |-> low_cnt_q == 8'(2*QTR)) else $error("scl low phase length");
  scl_high_a: assert property (
    $fell(scl_i) |-> high_cnt_q >= 8'(2*QTR)) else $error("scl high phase short");
  mst_move_a: assert property (
    $changed(m_sda_oe) && !scl_i |-> low_cnt_q != 8'h00 && low_cnt_q < 8'(2*QTR))
    else $error("master moved sda at scl edge");
  start_hold_a: assert property (
    start_c |=> (!sda_i)[*3]) else $error("sda not held after start");
  stop_idle_a: assert property (
    stop_c |=> sda_i[*8]) else $error("bus not idle after stop");
  tgt_quiet_a: assert property (
    !frame_q |-> !t_sda_oe) else $error("target drove outside frame");
  restart_c: cover property (start_c && frame_q);
  stop_c_c: cover property (stop_c);
  ack_c: cover property ($rose(t_sda_oe));
endmodule : two_wire_monitor

// >>> tb/tb.sv
// self-checking bench: master end and target end joined by the bus interface
// assumes the target reads a bank that the bench models as rd_ptr xor 5Ah
`timescale 1ns/1ps
module tb;
  import two_wire_pkg::*;
  localparam int Q     = 4;
  localparam int LIMIT = 20000;
  logic       sys_clk      = 1'b0;
  logic       rst_n        = 1'b0;
  logic       cmd_valid    = 1'b0;
  logic [1:0] cmd_op       = 2'h0;
  logic [7:0] cmd_data     = 8'h00;
  logic       cmd_nack     = 1'b0;
  logic       wr_ready     = 1'b0;
  logic       cmd_ready, rsp_valid, rsp_nack, rsp_refused, m_busy;
  logic       wr_valid, rd_load, t_busy, restart;
  logic [7:0] rsp_data, wr_addr, wr_data, rd_ptr, rd_data;
  int         miscompares  = 0;
  int         total_checks = 0;
  int         cyc          = 0;
  int         rs_cnt       = 0;
  int         ld_cnt       = 0;
  two_wire_if bus_if ();
  assign rd_data = rd_ptr ^ 8'h5A;
  two_wire_master_end #(.QTR(Q)) two_wire_master_end_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack), .rsp_refused(rsp_refused), .busy(m_busy));
  rtc_two_wire_target_port #(.FIFO_D(4)) rtc_two_wire_target_port_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .bus(bus_if), .wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_ptr(rd_ptr), .rd_data(rd_data), .rd_load(rd_load),
    .busy(t_busy), .restart(restart));
  two_wire_monitor #(.QTR(Q)) two_wire_monitor_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o),
    .m_sda_oe(bus_if.m_sda_oe), .t_sda_o(bus_if.t_sda_o), .t_sda_oe(bus_if.t_sda_oe),
    .scl_i(bus_if.scl_i), .sda_i(bus_if.sda_i));
  // ************************************************************
  // clock, watchdog, common tasks
  // ************************************************************
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (restart === 1'b1) rs_cnt++;
    if (rd_load === 1'b1) ld_cnt++;
    if (cyc == LIMIT) begin
      miscompares++;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // request held from a clock edge until the edge that takes it
  task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic nk);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_data  <= d;
    cmd_nack  <= nk;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    @(negedge sys_clk);
    if (op != OP_WRITE) check(16'(m_busy), 16'h0001);
    if (op == OP_WRITE || op == OP_READ) begin
      while (rsp_valid !== 1'b1) @(negedge sys_clk);
    end else begin
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
    end
  endtask : cmd
  task automatic wr(input logic [7:0] d, input logic nk);
    cmd(OP_WRITE, d, 1'b0);
    check(16'(rsp_nack), 16'(nk));
  endtask : wr
  task automatic pop(input logic [15:0] exp);
    @(negedge sys_clk);
    while (wr_valid !== 1'b1) @(negedge sys_clk);
    check({wr_addr, wr_data}, exp);
    @(posedge sys_clk);
    wr_ready <= 1'b1;
    @(posedge sys_clk);
    wr_ready <= 1'b0;
  endtask : pop
  task automatic results;
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_write;
    cmd(OP_START, 8'h00, 1'b0);
    check(16'(t_busy), 16'h0001);
    wr(8'hD0, 1'b0);
    wr(8'h10, 1'b0);
    wr(8'hA5, 1'b0);
    wr(8'h3C, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    repeat (4) @(negedge sys_clk);
    check(16'(t_busy), 16'h0000);
    check(16'(rd_ptr), 16'h0012);
    pop(16'h10A5);
    pop(16'h113C);
  endtask : t_write
  // fifo fills at four words, the fifth byte is refused with no ack
  task automatic t_full;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'hD0, 1'b0);
    wr(8'h20, 1'b0);
    for (int i = 0; i < 5; i++) wr(8'hB0 + 8'(i), i == 4);
    cmd(OP_STOP, 8'h00, 1'b0);
    check(16'(rd_ptr), 16'h0024);
    for (int i = 0; i < 4; i++) pop({8'h20 + 8'(i), 8'hB0 + 8'(i)});
    @(negedge sys_clk);
    check(16'(wr_valid), 16'h0000);
  endtask : t_full
  task automatic t_read;
    int base;
    base = ld_cnt;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'hD1, 1'b0);
    cmd(OP_READ, 8'h00, 1'b0);
    check(16'(rsp_data), 16'(8'h24 ^ 8'h5A));
    cmd(OP_READ, 8'h00, 1'b1);
    check(16'(rsp_data), 16'(8'h25 ^ 8'h5A));
    check(16'({bus_if.scl_i, bus_if.sda_i}), 16'h0003);
    cmd(OP_STOP, 8'h00, 1'b0);
    check(16'(rd_ptr), 16'h0026);
    check(16'(ld_cnt - base), 16'h0002);
  endtask : t_read
  task automatic t_badaddr;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'hA0, 1'b1);
    wr(8'h55, 1'b1);
    cmd(OP_STOP, 8'h00, 1'b0);
    check(16'(wr_valid), 16'h0000);
  endtask : t_badaddr
  // repeated start after a read that the master ended with no ack
  task automatic t_restart;
    int base;
    base = rs_cnt;
    cmd(OP_START, 8'h00, 1'b0);
    wr(8'hD1, 1'b0);
    cmd(OP_READ, 8'h00, 1'b1);
    check(16'(rsp_data), 16'(8'h26 ^ 8'h5A));
    cmd(OP_START, 8'h00, 1'b0);
    check(16'(rs_cnt - base), 16'h0001);
    wr(8'hD0, 1'b0);
    wr(8'h30, 1'b0);
    wr(8'h77, 1'b0);
    cmd(OP_STOP, 8'h00, 1'b0);
    pop(16'h3077);
    check(16'(rd_ptr), 16'h0031);
  endtask : t_restart
  // the master end refuses to point at the two test places
  task automatic t_refuse;
    logic [7:0] ta[2];
    ta = '{TEST_ADDR_A, TEST_ADDR_B};
    foreach (ta[i]) begin
      cmd(OP_START, 8'h00, 1'b0);
      wr(8'hD0, 1'b0);
      cmd(OP_WRITE, ta[i], 1'b0);
      check(16'(rsp_refused), 16'h0001);
      cmd(OP_STOP, 8'h00, 1'b0);
    end
    check(16'(rd_ptr), 16'h0031);
  endtask : t_refuse
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(16'({bus_if.scl_i, bus_if.sda_i, cmd_ready}), 16'h0007);
    t_write();
    t_full();
    t_read();
    t_badaddr();
    t_restart();
    t_refuse();
    results();
  end
endmodule : tb
